// ---- rtl/tmr_top.sv ----
// 8-bit timer/counter: registers, counter, compare, flags, outputs
// assumes an axi4-lite master on aclk and a processor vector acknowledge
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module tmr_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [2:0] vector_ack,
  output logic [2:0] irq_req,
  output logic irq,
  output logic wave_out_a,
  output logic wave_out_a_en_n,
  output logic wave_out_b,
  output logic wave_out_b_en_n
);
  logic [7:0] ctrl_a_output_wave;
  logic [7:0] ctrl_b_force_clock;
  logic [7:0] count_value;
  logic [7:0] cmp [2];
  logic [2:0] irq_enable_mask;
  logic [2:0] irq_flag_bits;
  logic gie;
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_strb_q;
  logic do_write;
  logic wr_ctrl_b;
  logic wr_count;
  logic wr_flags;
  logic block_q;
  logic up_q;
  logic [2:0] mode;
  logic [7:0] top;
  logic pc;
  logic at_top;
  logic ovf_ev;
  logic [1:0] match_ev;
  logic [1:0] force_hit;
  logic [1:0] om [2];
  logic [1:0] wave;
  logic [2:0] set_ev;
  logic [2:0] clr_ev;

  tmr_tick_if tk ();

  tmr_prescale u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .tk(tk)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus slave: write path

  assign awready = !aw_hold && !bvalid;
  assign wready = !w_hold && !bvalid;
  assign do_write = aw_hold && w_hold;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (awvalid && awready) begin
      aw_hold <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (do_write) begin
      aw_hold <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold <= 1'b0;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_hold <= 1'b1;
      w_data_q <= wdata[7:0];
      w_strb_q <= wstrb[0];
    end else if (do_write) begin
      w_hold <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= tmr_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= tmr_pkg::is_mapped(aw_addr_q) ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  function automatic logic wr_hit(input logic [7:0] off);
    return do_write && w_strb_q && (aw_addr_q == off);
  endfunction

  assign wr_ctrl_b = wr_hit(tmr_pkg::OFF_CTRL_B);
  assign wr_count = wr_hit(tmr_pkg::OFF_COUNT);
  assign wr_flags = wr_hit(tmr_pkg::OFF_FLAGS);

  ////////////////////////////////////////////////////////////////////////
  // bus slave: read path

  function automatic logic [7:0] read_mux(input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      tmr_pkg::OFF_CTRL_A: v = ctrl_a_output_wave;
      tmr_pkg::OFF_CTRL_B: v = ctrl_b_force_clock & tmr_pkg::CTRL_B_RW;
      tmr_pkg::OFF_COUNT: v = count_value;
      tmr_pkg::OFF_CMP_A: v = cmp[0];
      tmr_pkg::OFF_CMP_B: v = cmp[1];
      tmr_pkg::OFF_MASK: v = {5'h00, irq_enable_mask};
      tmr_pkg::OFF_FLAGS: v = {5'h00, irq_flag_bits};
      tmr_pkg::OFF_GIE: v = {7'h00, gie};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= tmr_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, read_mux(araddr)};
      rresp <= tmr_pkg::is_mapped(araddr) ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_output_wave <= tmr_pkg::RESET_BYTE;
      ctrl_b_force_clock <= tmr_pkg::RESET_BYTE;
      cmp[0] <= tmr_pkg::RESET_BYTE;
      cmp[1] <= tmr_pkg::RESET_BYTE;
      irq_enable_mask <= 3'h0;
      gie <= 1'b0;
    end else begin
      if (wr_hit(tmr_pkg::OFF_CTRL_A)) begin
        ctrl_a_output_wave <= w_data_q & tmr_pkg::CTRL_A_RW;
      end
      if (wr_ctrl_b) begin
        ctrl_b_force_clock <= w_data_q & tmr_pkg::CTRL_B_RW;
      end
      if (wr_hit(tmr_pkg::OFF_CMP_A)) begin
        cmp[0] <= w_data_q;
      end
      if (wr_hit(tmr_pkg::OFF_CMP_B)) begin
        cmp[1] <= w_data_q;
      end
      if (wr_hit(tmr_pkg::OFF_MASK)) begin
        irq_enable_mask <= w_data_q[2:0] & tmr_pkg::IRQ_RW;
      end
      if (wr_hit(tmr_pkg::OFF_GIE)) begin
        gie <= w_data_q[0];
      end
    end
  end

  assign tk.select = ctrl_b_force_clock[2:0];
  assign om[0] = ctrl_a_output_wave[7:6];
  assign om[1] = ctrl_a_output_wave[5:4];

  ////////////////////////////////////////////////////////////////////////
  // counter

  assign mode = {ctrl_b_force_clock[tmr_pkg::WAVE_HI_BIT], ctrl_a_output_wave[1:0]};
  assign pc = tmr_pkg::is_phase(mode);
  always_comb begin
    top = tmr_pkg::MAX;
    if (mode == tmr_pkg::MODE_CTC || mode == tmr_pkg::MODE_PC_CMP || mode == tmr_pkg::MODE_FAST_CMP) begin
      top = cmp[0];
    end
  end
  assign at_top = tk.tick && (count_value == top);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_value <= tmr_pkg::RESET_BYTE;
    end else if (wr_count) begin
      count_value <= w_data_q;
    end else if (tk.tick) begin
      if (pc && up_q && count_value == top) begin
        count_value <= count_value - 8'h01;
      end else if (pc && !up_q && count_value != tmr_pkg::BOTTOM) begin
        count_value <= count_value - 8'h01;
      end else if (!pc && count_value == top) begin
        count_value <= tmr_pkg::BOTTOM;
      end else begin
        count_value <= count_value + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_q <= 1'b1;
    end else if (!pc) begin
      up_q <= 1'b1;
    end else if (tk.tick && !wr_count) begin
      if (up_q && count_value == top) begin
        up_q <= 1'b0;
      end else if (!up_q && count_value == tmr_pkg::BOTTOM) begin
        up_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_q <= 1'b0;
    end else if (wr_count) begin
      block_q <= 1'b1;
    end else if (tk.tick) begin
      block_q <= 1'b0;
    end
  end

  always_comb begin
    ovf_ev = 1'b0;
    if (tk.tick && !wr_count) begin
      if (pc) begin
        ovf_ev = !up_q && (count_value == tmr_pkg::BOTTOM);
      end else if (mode == tmr_pkg::MODE_FAST_CMP) begin
        ovf_ev = count_value == top;
      end else begin
        ovf_ev = count_value == tmr_pkg::MAX;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // compare channels and waveform outputs

  function automatic logic wave_next(input logic [2:0] md, input logic [1:0] om_i, input logic cur,
                                     input logic hit, input logic forced, input logic top_hit,
                                     input logic up, input logic tog_ok);
    logic r;
    r = cur;
    if (!tmr_pkg::is_pwm(md)) begin
      if (hit || forced) begin
        case (om_i)
          tmr_pkg::OM_TOGGLE: r = !cur;
          tmr_pkg::OM_CLEAR: r = 1'b0;
          tmr_pkg::OM_SET: r = 1'b1;
          default: r = cur;
        endcase
      end
    end else if (om_i == tmr_pkg::OM_TOGGLE) begin
      if (tog_ok && md[2] && hit) begin
        r = !cur;
      end
    end else if (om_i[1]) begin
      if (tmr_pkg::is_fast(md) && top_hit) begin
        r = !om_i[0];
      end else if (tmr_pkg::is_fast(md) && hit) begin
        r = om_i[0];
      end else if (hit) begin
        r = up ? om_i[0] : !om_i[0];
      end
    end
    return r;
  endfunction

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    assign match_ev[ch] = tk.tick && !block_q && !wr_count && (count_value == cmp[ch]);
    assign force_hit[ch] = wr_ctrl_b && w_data_q[tmr_pkg::FORCE_A_BIT - ch] && !tmr_pkg::is_pwm(mode);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        wave[ch] <= 1'b0;
      end else begin
        wave[ch] <= wave_next(mode, om[ch], wave[ch], match_ev[ch], force_hit[ch], at_top, up_q, ch == 0);
      end
    end
  end

  assign wave_out_a = wave[0];
  assign wave_out_b = wave[1];
  // enables low while the pin is driven
  assign wave_out_a_en_n = om[0] == tmr_pkg::OM_OFF;
  assign wave_out_b_en_n = om[1] == tmr_pkg::OM_OFF;

  ////////////////////////////////////////////////////////////////////////
  // interrupt flags and requests

  assign set_ev = {match_ev[1], match_ev[0], ovf_ev};
  assign clr_ev = vector_ack | (wr_flags ? w_data_q[2:0] : 3'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_flag_bits <= 3'h0;
    end else begin
      irq_flag_bits <= (irq_flag_bits & ~clr_ev) | set_ev;
    end
  end

  assign irq_req = irq_flag_bits & irq_enable_mask & {3{gie}};
  assign irq = |irq_req;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence force_tog_s;
    force_hit[0] && om[0] == tmr_pkg::OM_TOGGLE && !match_ev[0];
  endsequence

  sequence pwm_strobe_s;
    wr_ctrl_b && w_data_q[tmr_pkg::FORCE_A_BIT] && tmr_pkg::is_pwm(mode) && !tk.tick;
  endsequence

  stop_no_tick_a: assert property (tk.select == 3'h0 |-> !tk.tick)
    else $error("tick while clock stopped");
  count_load_a: assert property (wr_count |=> count_value == $past(w_data_q) && block_q)
    else $error("counter write not loaded");
  block_match_a: assert property (block_q && tk.tick && !wr_count |-> match_ev == 2'h0 ##1 !block_q)
    else $error("match not masked after counter write");
  flag_set_a: assert property (match_ev[1] |=> irq_flag_bits[tmr_pkg::MATCH_B_BIT])
    else $error("match b flag not set");
  force_toggle_a: assert property (force_tog_s |=> wave[0] != $past(wave[0]))
    else $error("forced toggle missing");
  pwm_force_a: assert property (pwm_strobe_s |=> $stable(wave[0]))
    else $error("strobe acted in pwm mode");
  force_quiet_a: assert property (force_hit[0] && !tk.tick && vector_ack == 3'h0
                                  |=> irq_flag_bits == $past(irq_flag_bits))
    else $error("forced match touched flags");
  strobe_read_a: assert property (arvalid && arready && araddr == tmr_pkg::OFF_CTRL_B
                                  |=> rvalid && rdata[7:4] == 4'h0)
    else $error("strobe or reserved bit read nonzero");
  flag_clear_a: assert property (wr_flags && w_data_q[0] && !set_ev[0]
                                 |=> !irq_flag_bits[tmr_pkg::OVF_BIT])
    else $error("write one did not clear flag");
  ack_clear_a: assert property (vector_ack[1] && !set_ev[1] |=> !irq_flag_bits[tmr_pkg::MATCH_A_BIT])
    else $error("vector did not clear flag");
  pc_ovf_a: assert property (tk.tick && pc && !up_q && count_value == tmr_pkg::BOTTOM && !wr_count
                             |=> irq_flag_bits[tmr_pkg::OVF_BIT] && up_q)
    else $error("bottom reversal missed overflow");
  irq_raise_a: assert property (irq_flag_bits[0] && irq_enable_mask[0] && gie |-> irq && irq_req[0])
    else $error("overflow request missing");
endmodule

// ---- shared/tmr_pkg.sv ----
// constants and decoders for the 8-bit timer/counter register block
// assumes a 32-bit axi4-lite slave port and one synchronous clock
// How it works
// - force strobes act only outside pwm modes
// - force strobe applies match to output
// - forced match sets no flag, no clear
// - force strobe bits always read zero
// - reserved bits five and four read zero
// - clock select stops or divides source
// - counter register reads and loads counter
// - counter write masks next tick's matches
// - compare registers compared with counter continuously
// - counter equal compare sets match flag
// - match flag, enable, global raise request
// - overflow sets flag, request when enabled
// - phase correct pwm overflow flag at bottom reversal
// - vector execution clears its flag
// - writing one clears a flag
// - three mode bits pick sequence, top
// - non-pwm output modes toggle, clear, set
package tmr_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_CMP_A = 8'h0c;
  localparam logic [7:0] OFF_CMP_B = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_FLAGS = 8'h18;
  localparam logic [7:0] OFF_GIE = 8'h1c;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] CTRL_A_RW = 8'hf3;
  localparam logic [7:0] CTRL_B_RW = 8'h0f;
  localparam logic [2:0] IRQ_RW = 3'h7;
  localparam int FORCE_A_BIT = 7;
  localparam int FORCE_B_BIT = 6;
  localparam int WAVE_HI_BIT = 3;
  localparam int OVF_BIT = 0;
  localparam int MATCH_A_BIT = 1;
  localparam int MATCH_B_BIT = 2;
  localparam logic [7:0] BOTTOM = 8'h00;
  localparam logic [7:0] MAX = 8'hff;
  localparam logic [2:0] MODE_PC_FF = 3'h1;
  localparam logic [2:0] MODE_CTC = 3'h2;
  localparam logic [2:0] MODE_FAST_FF = 3'h3;
  localparam logic [2:0] MODE_PC_CMP = 3'h5;
  localparam logic [2:0] MODE_FAST_CMP = 3'h7;
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR = 2'h2;
  localparam logic [1:0] OM_SET = 2'h3;
  localparam int PRESCALE_W = 10;
  localparam logic [9:0] DIV_1 = 10'h000;
  localparam logic [9:0] DIV_8 = 10'h007;
  localparam logic [9:0] DIV_32 = 10'h01f;
  localparam logic [9:0] DIV_64 = 10'h03f;
  localparam logic [9:0] DIV_128 = 10'h07f;
  localparam logic [9:0] DIV_256 = 10'h0ff;
  localparam logic [9:0] DIV_1024 = 10'h3ff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic is_phase(input logic [2:0] mode);
    return (mode == MODE_PC_FF) || (mode == MODE_PC_CMP);
  endfunction

  function automatic logic is_fast(input logic [2:0] mode);
    return (mode == MODE_FAST_FF) || (mode == MODE_FAST_CMP);
  endfunction

  function automatic logic is_pwm(input logic [2:0] mode);
    return is_phase(mode) || is_fast(mode);
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    return (addr[1:0] == 2'h0) && (addr <= OFF_GIE);
  endfunction
endpackage

// ---- shared/tmr_tick_if.sv ----
// clock select and timer tick between register block and prescaler
// assumes both ends share aclk
`timescale 1ns/10ps
interface tmr_tick_if;
  logic [2:0] select;
  logic tick;
  modport ctl (output select, input tick);
  modport pre (input select, output tick);
endinterface

// ---- rtl/tmr_prescale.sv ----
// prescaler: divides the source clock into a one-cycle timer tick
// assumes the source clock is aclk itself
`timescale 1ns/10ps
module tmr_prescale (
  input wire logic aclk,
  input wire logic aresetn,
  tmr_tick_if.pre tk
);
  logic [tmr_pkg::PRESCALE_W-1:0] cnt;

  function automatic logic [9:0] div_mask(input logic [2:0] sel);
    logic [9:0] m;
    m = tmr_pkg::DIV_1;
    case (sel)
      3'h2: m = tmr_pkg::DIV_8;
      3'h3: m = tmr_pkg::DIV_32;
      3'h4: m = tmr_pkg::DIV_64;
      3'h5: m = tmr_pkg::DIV_128;
      3'h6: m = tmr_pkg::DIV_256;
      3'h7: m = tmr_pkg::DIV_1024;
      default: m = tmr_pkg::DIV_1;
    endcase
    return m;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 10'h001;
    end
  end

  assign tk.tick = (tk.select != 3'h0) && ((cnt & div_mask(tk.select)) == div_mask(tk.select));
endmodule

// ---- tb/tb_timer2_ctrl_count_irq.sv ----
// self-checking bench for the 8-bit timer register block
// assumes tmr_top behind an axi4-lite slave port on aclk
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_timer2_ctrl_count_irq;
  localparam logic [1:0] OMS [5] = '{2'h0, 2'h3, 2'h1, 2'h2, 2'h1};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [2:0] vector_ack = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic wave_out_a, wave_out_a_en_n, wave_out_b, wave_out_b_en_n;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] irq_req;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int t_rd;

  tmr_top i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .vector_ack, .irq_req, .irq, .wave_out_a, .wave_out_a_en_n, .wave_out_b, .wave_out_b_en_n);

  always #5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  initial begin
    repeat (30000) @(posedge aclk);
    fails++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic wave_fn(input logic [1:0] om, input logic cur);
    case (om)
      2'h1: return !cur;
      2'h2: return 1'b0;
      2'h3: return 1'b1;
      default: return cur;
    endcase
  endfunction

  function automatic int div_of(input int cs);
    int t [8] = '{2, 1, 8, 32, 64, 128, 256, 1024};
    return t[cs];
  endfunction

  // handshakes judged mid-cycle, released just after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = tmr_pkg::RESP_OKAY);
    logic pa, pw, pb, ha, hw;
    int n;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pb && n < 50) begin
      @(negedge aclk);
      ha = pa && awready;
      hw = pw && wready;
      if (!pa && !pw && bvalid) begin
        `CHK(bresp, er)
        pb = 1'b0;
      end
      @(posedge aclk);
      n++;
      if (ha) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (hw) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
    // bready stays up between writes; a wait that runs out is a mismatch
    `CHK(pb, 1'b0)
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, input logic [1:0] er = tmr_pkg::RESP_OKAY);
    logic pa, pr, ha;
    int n;
    pa = 1'b1;
    pr = 1'b1;
    n = 0;
    d = 8'h00;
    t_rd = cyc;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (pr && n < 50) begin
      @(negedge aclk);
      ha = pa && arready;
      if (!pa && rvalid) begin
        `CHK(rresp, er)
        `CHK(rdata[31:8], 24'h0)
        d = rdata[7:0];
        pr = 1'b0;
      end
      @(posedge aclk);
      n++;
      if (ha) begin
        pa = 1'b0;
        arvalid <= 1'b0;
      end
    end
    `CHK(pr, 1'b0)
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK(v, e)
  endtask

  task automatic chk_irq(input logic [2:0] e);
    @(negedge aclk);
    `CHK({irq, irq_req}, {|e, e})
    @(posedge aclk);
  endtask

  task automatic ack(input logic [2:0] e);
    vector_ack <= e;
    @(posedge aclk);
    vector_ack <= 3'h0;
  endtask

  task automatic end_of_test();
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v, v0, r, a8;
    logic ex;
    int t1;
    v = 8'($urandom(32'h649b));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int a = 0; a < 32; a += 4) begin
      chk_rd(8'(a), 8'h00);
    end
    wr(tmr_pkg::OFF_CTRL_B, 8'hff);
    chk_rd(tmr_pkg::OFF_CTRL_B, 8'h0f);
    wr(tmr_pkg::OFF_CTRL_B, 8'h00);
    wr(tmr_pkg::OFF_MASK, 8'hff);
    chk_rd(tmr_pkg::OFF_MASK, 8'h07);
    wr(tmr_pkg::OFF_MASK, 8'h00);
    wr(8'h20, 8'h55, tmr_pkg::RESP_SLVERR);
    rd(8'h22, v, tmr_pkg::RESP_SLVERR);
    `CHK(v, 8'h00)
    repeat (6) begin
      a8 = tmr_pkg::OFF_COUNT + 8'($urandom_range(0, 2) * 4);
      r = 8'($urandom);
      wr(a8, r);
      chk_rd(a8, r);
    end
    wr(tmr_pkg::OFF_CMP_A, 8'h10);
    wr(tmr_pkg::OFF_COUNT, 8'h10);
    ex = 1'b0;
    foreach (OMS[i]) begin
      wr(tmr_pkg::OFF_CTRL_A, {OMS[i], OMS[i], 2'h0, tmr_pkg::MODE_CTC[1:0]});
      wr(tmr_pkg::OFF_CTRL_B, 8'hc0);
      ex = wave_fn(OMS[i], ex);
      @(negedge aclk);
      `CHK({wave_out_a_en_n, wave_out_b_en_n}, {2{OMS[i] == 2'h0}})
      if (OMS[i] != 2'h0) `CHK({wave_out_a, wave_out_b}, {ex, ex})
      @(posedge aclk);
    end
    chk_rd(tmr_pkg::OFF_COUNT, 8'h10);
    chk_rd(tmr_pkg::OFF_FLAGS, 8'h00);
    wr(tmr_pkg::OFF_CTRL_A, {2'h1, 2'h1, 2'h0, tmr_pkg::MODE_FAST_FF[1:0]});
    wr(tmr_pkg::OFF_CTRL_B, 8'hc0);
    @(negedge aclk);
    `CHK({wave_out_a, wave_out_b}, {ex, ex})
    @(posedge aclk);
    // strobes written as zero from here on
    wr(tmr_pkg::OFF_CTRL_A, 8'h00);
    // tick count over a window of four divided periods
    for (int cs = 0; cs < 8; cs++) begin
      wr(tmr_pkg::OFF_CTRL_B, 8'(cs));
      rd(tmr_pkg::OFF_COUNT, v0);
      t1 = t_rd;
      while (cyc != t1 + 4 * div_of(cs)) @(posedge aclk);
      rd(tmr_pkg::OFF_COUNT, v);
      `CHK(8'(v - v0), (cs == 0) ? 8'h00 : 8'h04)
    end
    // counter write hides the next match
    wr(tmr_pkg::OFF_CTRL_B, 8'h00);
    wr(tmr_pkg::OFF_CMP_A, 8'h40);
    wr(tmr_pkg::OFF_CMP_B, 8'hff);
    for (int k = 0; k < 2; k++) begin
      wr(tmr_pkg::OFF_FLAGS, 8'h07);
      wr(tmr_pkg::OFF_COUNT, 8'h40 - 8'(k));
      wr(tmr_pkg::OFF_CTRL_B, 8'h01);
      wr(tmr_pkg::OFF_CTRL_B, 8'h00);
      chk_rd(tmr_pkg::OFF_FLAGS, {6'h0, 1'(k), 1'b0});
    end
    r = 8'($urandom_range(40, 200));
    wr(tmr_pkg::OFF_CMP_A, r);
    wr(tmr_pkg::OFF_CMP_B, r + 8'h03);
    wr(tmr_pkg::OFF_COUNT, r - 8'h05);
    wr(tmr_pkg::OFF_GIE, 8'h01);
    wr(tmr_pkg::OFF_CTRL_B, 8'h01);
    repeat (20) @(posedge aclk);
    wr(tmr_pkg::OFF_CTRL_B, 8'h00);
    chk_rd(tmr_pkg::OFF_FLAGS, 8'h06);
    chk_irq(3'b000);
    wr(tmr_pkg::OFF_MASK, 8'h02);
    chk_irq(3'b010);
    wr(tmr_pkg::OFF_GIE, 8'h00);
    chk_irq(3'b000);
    wr(tmr_pkg::OFF_GIE, 8'h01);
    wr(tmr_pkg::OFF_FLAGS, 8'h00);
    chk_rd(tmr_pkg::OFF_FLAGS, 8'h06);
    wr(tmr_pkg::OFF_FLAGS, 8'h02);
    chk_rd(tmr_pkg::OFF_FLAGS, 8'h04);
    chk_irq(3'b000);
    ack(3'b100);
    chk_rd(tmr_pkg::OFF_FLAGS, 8'h00);
    wr(tmr_pkg::OFF_CMP_A, 8'h80);
    wr(tmr_pkg::OFF_CMP_B, 8'h80);
    wr(tmr_pkg::OFF_MASK, 8'h01);
    wr(tmr_pkg::OFF_COUNT, 8'hfd);
    wr(tmr_pkg::OFF_CTRL_B, 8'h01);
    repeat (10) @(posedge aclk);
    wr(tmr_pkg::OFF_CTRL_B, 8'h00);
    chk_rd(tmr_pkg::OFF_FLAGS, 8'h01);
    chk_irq(3'b001);
    ack(3'b011);
    chk_rd(tmr_pkg::OFF_FLAGS, 8'h00);
    // phase correct overflow at bottom only
    wr(tmr_pkg::OFF_CTRL_A, {6'h0, tmr_pkg::MODE_PC_FF[1:0]});
    wr(tmr_pkg::OFF_COUNT, 8'hfe);
    wr(tmr_pkg::OFF_CTRL_B, 8'h01);
    repeat (20) @(posedge aclk);
    chk_rd(tmr_pkg::OFF_FLAGS, 8'h00);
    repeat (300) @(posedge aclk);
    wr(tmr_pkg::OFF_CTRL_B, 8'h00);
    rd(tmr_pkg::OFF_FLAGS, v);
    `CHK(v[0], 1'b1)
    wr(tmr_pkg::OFF_CTRL_A, {6'h0, tmr_pkg::MODE_CTC[1:0]});
    wr(tmr_pkg::OFF_CMP_A, 8'h03);
    wr(tmr_pkg::OFF_COUNT, 8'h00);
    wr(tmr_pkg::OFF_FLAGS, 8'h07);
    wr(tmr_pkg::OFF_CTRL_B, 8'h01);
    repeat (20) @(posedge aclk);
    wr(tmr_pkg::OFF_CTRL_B, 8'h00);
    rd(tmr_pkg::OFF_COUNT, v);
    `CHK(v <= 8'h03, 1'b1)
    chk_rd(tmr_pkg::OFF_FLAGS, 8'h02);
    end_of_test();
  end
endmodule
